// *** src/cwd_cfg.svh ***
// constants for the configuration word decoder and control register
// assumes nothing beyond a SystemVerilog compiler
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH

// pll word field positions
`define CWD_ODIV_MSB      18
`define CWD_ODIV_LSB      16
`define CWD_UPLL_BYP_BIT  15
`define CWD_UIDIV_MSB     10
`define CWD_UIDIV_LSB     8
`define CWD_MUL_MSB       6
`define CWD_MUL_LSB       4
`define CWD_IDIV_MSB      2
`define CWD_IDIV_LSB      0
// reserved bits of the pll word, written as ones
`define CWD_PLL_RSVD_MASK 32'hFFF87888
// pin-policy word field positions
`define CWD_VBUS_OWN_BIT  31
`define CWD_ID_OWN_BIT    30
`define CWD_MAP_1WAY_BIT  29
`define CWD_DIS_1WAY_BIT  28
`define CWD_PIN_RSVD_MASK 32'h0FFF0000
// control register
`define CWD_CC_MAP_LOCK   13
`define CWD_CC_DIS_LOCK   12
`define CWD_CC_JTAG_EN    3
`define CWD_CC_TDO_EN     0
`define CWD_CC_ONES       32'h00000006
// register offsets on the local register port
`define CWD_OFS_PLL       2'h0
`define CWD_OFS_PIN       2'h1
`define CWD_OFS_CTRL      2'h2
// unlock sequence keys
`define CWD_KEY1          32'hAA996655
`define CWD_KEY2          32'h556699AA

`endif

// *** src/cwd_pkg.sv ***
// types for the configuration word decoder
// assumes cwd_cfg.svh supplies the numeric constants
package cwd_pkg;
   // decoded clock settings
   typedef struct packed {
      logic [8:0] pll_out_div;    // 1..256
      logic       usb_pll_bypass;
      logic [3:0] usb_in_div;     // 1..12
      logic [4:0] pll_mul;        // 15..24
      logic [3:0] pll_in_div;     // 1..12
   } cwd_clk_type;

   // pin ownership and policy outputs
   typedef struct packed {
      logic        vbus_by_usb;
      logic        id_by_usb;
      logic        pin_map_single;
      logic        mod_dis_single;
      logic [15:0] user_id_value;
   } cwd_pin_type;

   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  addr;
      logic [31:0] wdata;
   } cwd_req_type;

   // unlock states, gray coded
   typedef enum logic [1:0] {
      CWD_LOCKED = 2'b00,
      CWD_KEY1OK = 2'b01,
      CWD_OPEN   = 2'b11
   } cwd_unl_type;

   // whole module state
   typedef struct packed {
      logic [31:0] pll_word;
      logic [31:0] pin_word;
      logic        loaded;
      logic        pin_map_lock;
      logic        mod_dis_lock;
      logic        pin_map_done;
      logic        mod_dis_done;
      logic        jtag_en;
      logic        tdo_en;
      cwd_unl_type unl;
      logic [31:0] rdata;
   } cwd_state_type;
endpackage : cwd_pkg

// *** src/cwd_top.sv ***
// configuration word decoder with the runtime control register
// assumes nonvolatile words are stable while reset_i is high and for the
// first clock after release; register port is a simple local strobe port
`include "cwd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cwd_top (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   // nonvolatile words
   input  wire logic [31:0]         nv_pll_word_i,
   input  wire logic [31:0]         nv_pin_word_i,
   input  wire logic                nv_jtag_en_i,
   // register port
   input  wire cwd_pkg::cwd_req_type req_i,
   output logic [31:0]              rdata_o,
   // decoded settings
   output cwd_pkg::cwd_clk_type     clk_cfg_o,
   output cwd_pkg::cwd_pin_type     pin_cfg_o,
   output logic                     rsvd_ok_o,
   // lock and debug outputs
   output logic                     map_write_ok_o,
   output logic                     dis_write_ok_o,
   output logic                     jtag_port_enable_o,
   output logic                     two_wire_data_out_enable_o
);
   import cwd_pkg::*;

   cwd_state_type st_r;
   cwd_state_type st_nxt;
   logic [31:0]   ctrl_view;
   logic          ctrl_wr;
   logic          unl_wr;

   // maps a 3-bit divider code to 1,2,3,4,5,6,10,12; used twice
   function automatic logic [3:0] cwd_in_div(input logic [2:0] c);
      unique case (c)
         3'h6:    cwd_in_div = 4'hA;
         3'h7:    cwd_in_div = 4'hC;
         default: cwd_in_div = {1'b0, c} + 4'h1;
      endcase
   endfunction

   // decode of the latched words
   always_comb begin
      clk_cfg_o.pll_out_div = (st_r.pll_word[`CWD_ODIV_MSB:`CWD_ODIV_LSB]
                               == 3'h7) ? 9'h100 :
         9'h001 << st_r.pll_word[`CWD_ODIV_MSB:`CWD_ODIV_LSB];
      clk_cfg_o.usb_pll_bypass = st_r.pll_word[`CWD_UPLL_BYP_BIT];
      clk_cfg_o.usb_in_div = cwd_in_div(
         st_r.pll_word[`CWD_UIDIV_MSB:`CWD_UIDIV_LSB]);
      clk_cfg_o.pll_mul = (st_r.pll_word[`CWD_MUL_MSB:`CWD_MUL_LSB]
                           == 3'h7) ? 5'h18 :
         5'h0F + {2'h0, st_r.pll_word[`CWD_MUL_MSB:`CWD_MUL_LSB]};
      clk_cfg_o.pll_in_div = cwd_in_div(
         st_r.pll_word[`CWD_IDIV_MSB:`CWD_IDIV_LSB]);
   end

   // pin ownership straight from the policy word
   assign pin_cfg_o.vbus_by_usb   = st_r.pin_word[`CWD_VBUS_OWN_BIT];
   assign pin_cfg_o.id_by_usb     = st_r.pin_word[`CWD_ID_OWN_BIT];
   assign pin_cfg_o.pin_map_single = st_r.pin_word[`CWD_MAP_1WAY_BIT];
   assign pin_cfg_o.mod_dis_single = st_r.pin_word[`CWD_DIS_1WAY_BIT];
   assign pin_cfg_o.user_id_value = st_r.pin_word[15:0];

   // flag words whose reserved bits are not all ones; only a warning
   assign rsvd_ok_o = ((st_r.pll_word & (`CWD_PLL_RSVD_MASK)) ==
                       (`CWD_PLL_RSVD_MASK)) &&
                      ((st_r.pin_word & `CWD_PIN_RSVD_MASK) ==
                       `CWD_PIN_RSVD_MASK);

   assign map_write_ok_o             = ~st_r.pin_map_lock;
   assign dis_write_ok_o             = ~st_r.mod_dis_lock;
   assign jtag_port_enable_o         = st_r.jtag_en;
   assign two_wire_data_out_enable_o = st_r.tdo_en;
   assign rdata_o                    = st_r.rdata;

   // control register as read: fixed bits per layout
   always_comb begin
      ctrl_view = `CWD_CC_ONES;
      ctrl_view[`CWD_CC_MAP_LOCK] = st_r.pin_map_lock;
      ctrl_view[`CWD_CC_DIS_LOCK] = st_r.mod_dis_lock;
      ctrl_view[`CWD_CC_JTAG_EN]  = st_r.jtag_en;
      ctrl_view[`CWD_CC_TDO_EN]   = st_r.tdo_en;
   end

   assign ctrl_wr = req_i.wr && (req_i.addr == `CWD_OFS_CTRL);
   assign unl_wr  = req_i.wr && (req_i.addr == 2'h3);

   // next state
   always_comb begin
      st_nxt = st_r;
      // words and jtag default caught on the first clock after release
      if (!st_r.loaded) begin
         st_nxt.pll_word = nv_pll_word_i;
         st_nxt.pin_word = nv_pin_word_i;
         st_nxt.jtag_en  = nv_jtag_en_i;
         st_nxt.loaded   = 1'b1;
      end
      // unlock walk: key1 then key2 on the key address
      unique case (st_r.unl)
         CWD_LOCKED: if (unl_wr && req_i.wdata == `CWD_KEY1)
            st_nxt.unl = CWD_KEY1OK;
         CWD_KEY1OK: if (unl_wr)
            st_nxt.unl = (req_i.wdata == `CWD_KEY2) ? CWD_OPEN : CWD_LOCKED;
         CWD_OPEN:   if (unl_wr)
            st_nxt.unl = CWD_LOCKED;
         default:    st_nxt.unl = CWD_LOCKED;
      endcase
      if (ctrl_wr && st_r.loaded) begin
         st_nxt.jtag_en = req_i.wdata[`CWD_CC_JTAG_EN];
         st_nxt.tdo_en  = req_i.wdata[`CWD_CC_TDO_EN];
         // lock bits move only when open and not spent
         if (st_r.unl == CWD_OPEN) begin
            if (!(st_r.pin_word[`CWD_MAP_1WAY_BIT] && st_r.pin_map_done) &&
                req_i.wdata[`CWD_CC_MAP_LOCK] != st_r.pin_map_lock) begin
               st_nxt.pin_map_lock = req_i.wdata[`CWD_CC_MAP_LOCK];
               if (req_i.wdata[`CWD_CC_MAP_LOCK])
                  st_nxt.pin_map_done = 1'b1;
            end
            if (!(st_r.pin_word[`CWD_DIS_1WAY_BIT] && st_r.mod_dis_done) &&
                req_i.wdata[`CWD_CC_DIS_LOCK] != st_r.mod_dis_lock) begin
               st_nxt.mod_dis_lock = req_i.wdata[`CWD_CC_DIS_LOCK];
               if (req_i.wdata[`CWD_CC_DIS_LOCK])
                  st_nxt.mod_dis_done = 1'b1;
            end
         end
      end
      // registered read data, words read-only
      if (req_i.rd) begin
         unique case (req_i.addr)
            `CWD_OFS_PLL:  st_nxt.rdata = st_r.pll_word;
            `CWD_OFS_PIN:  st_nxt.rdata = st_r.pin_word;
            `CWD_OFS_CTRL: st_nxt.rdata = ctrl_view;
            default:       st_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   // state register; words reset to all ones like erased storage
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r          <= '0;
         st_r.pll_word <= 32'hFFFFFFFF;
         st_r.pin_word <= 32'hFFFFFFFF;
         st_r.jtag_en  <= 1'b1;
         st_r.tdo_en   <= 1'b1;
         st_r.unl      <= CWD_LOCKED;
      end else begin
         st_r <= st_nxt;
      end
   end

   // assertions
   chk_lock_needs_key: assert property (@(posedge clk_i) disable iff (reset_i)
      $changed(st_r.pin_map_lock) |-> $past(st_r.unl) == CWD_OPEN)
      else $error("pin-map lock moved while locked");
   chk_dis_key: assert property (@(posedge clk_i) disable iff (reset_i)
      $changed(st_r.mod_dis_lock) |-> $past(st_r.unl) == CWD_OPEN &&
      $past(ctrl_wr))
      else $error("module lock moved without write");
   chk_map_one_way: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pin_word[`CWD_MAP_1WAY_BIT] && st_r.pin_map_done && st_r.loaded
      |=> $stable(st_r.pin_map_lock))
      else $error("pin-map relocked twice");
   chk_dis_one_way: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pin_word[`CWD_DIS_1WAY_BIT] && st_r.mod_dis_done && st_r.loaded
      |=> $stable(st_r.mod_dis_lock))
      else $error("module lock changed twice");
   chk_words_stable: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.loaded |=> $stable(st_r.pll_word) && $stable(st_r.pin_word))
      else $error("config words changed");
   chk_ctrl_fixed: assert property (@(posedge clk_i) disable iff (reset_i)
      $past(req_i.rd) && $past(req_i.addr) == `CWD_OFS_CTRL |->
      (rdata_o & 32'hFFFFCFF6) == `CWD_CC_ONES)
      else $error("fixed control bits wrong");
   chk_odiv_top: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[18:16] == 3'h7 |-> clk_cfg_o.pll_out_div == 9'h100)
      else $error("divide by 256 wrong");
   chk_mul_top: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[6:4] == 3'h7 |-> clk_cfg_o.pll_mul == 5'h18)
      else $error("multiply by 24 wrong");
   chk_tdo_write: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr && st_r.loaded |=> st_r.tdo_en == $past(req_i.wdata[0]))
      else $error("tdo enable not written");
   chk_jtag_load: assert property (@(posedge clk_i) disable iff (reset_i)
      !st_r.loaded |=> st_r.jtag_en == $past(nv_jtag_en_i))
      else $error("jtag default not loaded");

   // named steps of the unlock walk, shared by the key checks below
   sequence cwd_key1_seq;
      unl_wr && req_i.wdata == `CWD_KEY1;
   endsequence

   sequence cwd_key2_seq;
      unl_wr && req_i.wdata == `CWD_KEY2;
   endsequence

   // first key from the locked state arms the walk
   chk_key1_step: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.unl == CWD_LOCKED ##0 cwd_key1_seq |=> st_r.unl == CWD_KEY1OK)
      else $error("first key not taken");

   // second key right after the first opens the lock bits
   chk_key2_step: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.unl == CWD_KEY1OK ##0 cwd_key2_seq |=> st_r.unl == CWD_OPEN)
      else $error("second key not taken");

   // any key-address write while open closes again
   chk_open_relock: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.unl == CWD_OPEN && unl_wr |=> st_r.unl == CWD_LOCKED)
      else $error("open state not closed");

   // a control write while closed leaves both locks alone
   chk_locked_ctrl: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr && st_r.unl != CWD_OPEN |=>
      $stable(st_r.pin_map_lock) && $stable(st_r.mod_dis_lock))
      else $error("lock moved while closed");

   // open and not spent: the pin-map lock follows the write
   chk_map_set: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr && st_r.loaded && st_r.unl == CWD_OPEN &&
      !(st_r.pin_word[`CWD_MAP_1WAY_BIT] && st_r.pin_map_done) |=>
      map_write_ok_o == !$past(req_i.wdata[`CWD_CC_MAP_LOCK]))
      else $error("pin-map lock not written");

   // open and not spent: the module-disable lock follows the write
   chk_dis_set: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr && st_r.loaded && st_r.unl == CWD_OPEN &&
      !(st_r.pin_word[`CWD_DIS_1WAY_BIT] && st_r.mod_dis_done) |=>
      dis_write_ok_o == !$past(req_i.wdata[`CWD_CC_DIS_LOCK]))
      else $error("module lock not written");

   // jtag enable takes bit 3 of every control write once the words are latched
   chk_jtag_write: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr && st_r.loaded |=> jtag_port_enable_o == $past(req_i.wdata[3]))
      else $error("jtag enable not written");

   // output divisor code 000 divides by one
   chk_odiv_low: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[18:16] == 3'h0 |-> clk_cfg_o.pll_out_div == 9'h001)
      else $error("divide by one wrong");

   // multiplier code 000 is fifteen
   chk_mul_low: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[6:4] == 3'h0 |-> clk_cfg_o.pll_mul == 5'h0F)
      else $error("multiply by 15 wrong");

   // usb pll bit passes through as the bypass flag
   chk_bypass_bit: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.loaded |-> clk_cfg_o.usb_pll_bypass == st_r.pll_word[15])
      else $error("usb pll bypass wrong");

   // usb input divider top code is twelve
   chk_uidiv_top: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[10:8] == 3'h7 |-> clk_cfg_o.usb_in_div == 4'hC)
      else $error("usb divide by 12 wrong");

   // usb input divider code 110 is ten, not seven
   chk_uidiv_ten: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[10:8] == 3'h6 |-> clk_cfg_o.usb_in_div == 4'hA)
      else $error("usb divide by 10 wrong");

   // system input divider top code is twelve
   chk_idiv_top: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[2:0] == 3'h7 |-> clk_cfg_o.pll_in_div == 4'hC)
      else $error("divide by 12 wrong");

   // system input divider code 000 is one
   chk_idiv_one: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word[2:0] == 3'h0 |-> clk_cfg_o.pll_in_div == 4'h1)
      else $error("input divide by one wrong");

   // power-switch pin owner follows bit 31
   chk_vbus_owner: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.loaded |-> pin_cfg_o.vbus_by_usb == st_r.pin_word[31])
      else $error("power pin owner wrong");

   // id pin owner follows bit 30
   chk_id_owner: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.loaded |-> pin_cfg_o.id_by_usb == st_r.pin_word[30])
      else $error("id pin owner wrong");

   // user value is the low half of the policy word
   chk_user_id: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.loaded |-> pin_cfg_o.user_id_value == st_r.pin_word[15:0])
      else $error("user value wrong");

   // erased words carry all reserved ones
   chk_rsvd_flag: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.pll_word == 32'hFFFFFFFF && st_r.pin_word == 32'hFFFFFFFF
      |-> rsvd_ok_o)
      else $error("reserved flag low on erased words");

   // a cleared reserved bit drops the flag
   chk_rsvd_bad: assert property (@(posedge clk_i) disable iff (reset_i)
      !st_r.pll_word[19] |-> !rsvd_ok_o)
      else $error("reserved flag missed a zero");

   // read data stands until the next read
   chk_rdata_holds: assert property (@(posedge clk_i) disable iff (reset_i)
      !req_i.rd |=> $stable(rdata_o))
      else $error("read data moved without read");

   // pll word reads back as latched
   chk_pll_read: assert property (@(posedge clk_i) disable iff (reset_i)
      $past(req_i.rd) && $past(req_i.addr) == `CWD_OFS_PLL |->
      rdata_o == st_r.pll_word)
      else $error("pll word read wrong");

   // policy word reads back as latched
   chk_pin_read: assert property (@(posedge clk_i) disable iff (reset_i)
      $past(req_i.rd) && $past(req_i.addr) == `CWD_OFS_PIN |->
      rdata_o == st_r.pin_word)
      else $error("policy word read wrong");

   // key register is write-only and reads zero
   chk_key_reads: assert property (@(posedge clk_i) disable iff (reset_i)
      $past(req_i.rd) && $past(req_i.addr) == 2'h3 |-> rdata_o == 32'h0)
      else $error("key register read not zero");

   // once latched the words stay latched until reset
   chk_loaded_stays: assert property (@(posedge clk_i) disable iff (reset_i)
      st_r.loaded |=> st_r.loaded)
      else $error("load flag dropped");
endmodule : cwd_top // cwd_top

`default_nettype wire

// *** dv/cwd_nv_model.sv ***
// nonvolatile word source standing in for the external programmer
// assumes the bench supplies raw word contents and a fault request
`timescale 1ns/1ps
`default_nettype none

module cwd_nv_model (
   // raw contents chosen by the bench
   input  wire logic [31:0] raw_pll_i,
   input  wire logic [31:0] raw_pin_i,
   input  wire logic        bad_i,
   // words as the programmer leaves them
   output logic [31:0]      pll_word_o,
   output logic [31:0]      pin_word_o
);
   // reserved bits go in as ones; bad_i drops bit 19 to provoke the flag
   assign pll_word_o = (raw_pll_i | 32'hFFF87888)
                       & ~{12'h0, bad_i, 19'h0};
   assign pin_word_o = raw_pin_i | 32'h0FFF0000;
endmodule // cwd_nv_model

`default_nettype wire

// *** dv/cwd_tb_top.sv ***
// self-checking bench for the configuration word decoder
// assumes cwd_pkg, cwd_top and cwd_nv_model are compiled before it
`include "cwd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cwd_tb_top;
   import cwd_pkg::*;
   logic        clk_i   = 1'b0;
   logic        reset_i = 1'b1;
   logic [31:0] raw_pll = 32'hFFFFFFFF;
   logic [31:0] raw_pin = 32'hFFFFFFFF;
   logic        bad     = 1'b0;
   logic        jtag_nv = 1'b1;
   cwd_req_type req     = '0;
   logic [31:0] pll_w, pin_w, rdata, rd_v;
   cwd_clk_type clk_cfg;
   cwd_pin_type pin_cfg;
   logic        rsvd_ok, map_ok, dis_ok, jtag_o, tdo_o;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   int          cyc        = 0;

   cwd_nv_model i_nv (.raw_pll_i(raw_pll), .raw_pin_i(raw_pin), .bad_i(bad),
                      .pll_word_o(pll_w), .pin_word_o(pin_w));
   cwd_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .nv_pll_word_i(pll_w),
                  .nv_pin_word_i(pin_w), .nv_jtag_en_i(jtag_nv),
                  .req_i(req), .rdata_o(rdata), .clk_cfg_o(clk_cfg),
                  .pin_cfg_o(pin_cfg), .rsvd_ok_o(rsvd_ok),
                  .map_write_ok_o(map_ok), .dis_write_ok_o(dis_ok),
                  .jtag_port_enable_o(jtag_o),
                  .two_wire_data_out_enable_o(tdo_o));

   // 20 MHz system clock
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard, run needs about nine hundred and forty cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      tests_run++;
      if (a !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   // one strobe cycle; read data sampled once it has registered
   task automatic bus(input logic w, input logic [1:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      req <= '0;
      #1 rd_v = rdata;
   endtask

   // a dummy key write first: an open state would eat key1 as a relock
   task automatic unlock();
      bus(1'b1, 2'h3, 32'h0);
      bus(1'b1, 2'h3, `CWD_KEY1);
      bus(1'b1, 2'h3, `CWD_KEY2);
   endtask

   // write control, read it back and compare the lock and debug outputs
   task automatic ctl(input logic [31:0] d, input logic [1:0] l,
                      input logic j, input logic t);
      bus(1'b1, `CWD_OFS_CTRL, d);
      bus(1'b0, `CWD_OFS_CTRL, 32'h0);
      chk({18'h0, l, 8'h0, j, 2'h3, t}, rd_v);
      chk({28'h0, !l[1], !l[0], j, t}, {28'h0, map_ok, dis_ok, jtag_o, tdo_o});
   endtask

   // divider table shared by both input dividers
   function automatic logic [3:0] dv(input logic [2:0] c);
      return (c == 3'h6) ? 4'hA : (c == 3'h7) ? 4'hC : 4'(c) + 4'h1;
   endfunction

   // decoded clock settings in the order of the output struct
   function automatic logic [31:0] ck(input logic [31:0] w);
      logic [8:0] od;
      logic [4:0] ml;
      od = (w[18:16] == 3'h7) ? 9'h100 : (9'h1 << w[18:16]);
      ml = (w[6:4] == 3'h7) ? 5'h18 : 5'hF + 5'(w[6:4]);
      return {9'h0, od, w[15], dv(w[10:8]), ml, dv(w[2:0])};
   endfunction

   // first eight rounds walk every pll field code, the first four every pin flag code; the rest are random
   initial begin
      void'($urandom(39987));
      for (int i = 0; i < 12; i++) begin
         raw_pll <= (i < 8) ? {13'h0, 3'(i), 1'(i), 4'h0, 3'(i), 1'h0, 3'(i),
                               1'h0, 3'(i)} : $urandom;
         raw_pin <= (i < 4) ? {2'(i), 2'(i), 12'h0, 16'(i * 4369)} : $urandom;
         bad <= (i == 5);
         jtag_nv <= i[0];
         reset_i <= 1'b1;
         repeat (20) @(posedge clk_i);
         reset_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         #1;
         chk(ck(pll_w), 32'(clk_cfg));
         chk({12'h0, pin_w[31:28], pin_w[15:0]}, 32'(pin_cfg));
         chk(32'(!bad), 32'(rsvd_ok));
         bus(1'b1, `CWD_OFS_PLL, ~pll_w);
         bus(1'b1, `CWD_OFS_PIN, $urandom);
         bus(1'b0, `CWD_OFS_PLL, 32'h0);
         chk(pll_w, rd_v);
         bus(1'b0, `CWD_OFS_PIN, 32'h0);
         chk(pin_w, rd_v);
         bus(1'b0, `CWD_OFS_CTRL, 32'h0);
         chk({28'h0, jtag_nv, 3'h7}, rd_v);
         ctl(32'h3000, 2'h0, 1'b0, 1'b0);
         unlock();
         ctl(32'h3009, 2'h3, 1'b1, 1'b1);
         unlock();
         ctl(32'h0, pin_w[29:28], 1'b0, 1'b0);
         unlock();
         ctl($urandom | 32'h3009, 2'h3, 1'b1, 1'b1);
         bus(1'b1, 2'h3, `CWD_KEY1);
         bus(1'b1, 2'h3, $urandom);
         bus(1'b1, 2'h3, `CWD_KEY2);
         ctl(32'h1, 2'h3, 1'b0, 1'b1);
         bus(1'b0, 2'h3, 32'h0);
         chk(32'h0, rd_v);
      end
      results();
   end
endmodule // cwd_tb_top

`default_nettype wire
